// ### common/mirg_consts.svh
`ifndef MIRG_CONSTS_SVH
`define MIRG_CONSTS_SVH

// Register byte offsets
`define MIRG_OFS_FLAGS      8'h00
`define MIRG_OFS_ENABLE     8'h04
`define MIRG_OFS_CTRL       8'h08
`define MIRG_OFS_EDGE       8'h0c
`define MIRG_OFS_STATUS     8'h10

// Source bit positions in the flag and enable registers
`define MIRG_BIT_EXT_A      0
`define MIRG_BIT_EXT_B      1
`define MIRG_BIT_BT         4
`define MIRG_BIT_TCA        5
`define MIRG_BIT_TCB        6
`define MIRG_SRC_MASK       8'h73

// Control register fields
`define MIRG_BIT_GIE        7

// Port edge control fields
`define MIRG_BIT_ETE        7
`define MIRG_SEL_LO         3
`define MIRG_SEL_HI         4
`define MIRG_SEL_FALL       2'h1
`define MIRG_SEL_RISE       2'h2
`define MIRG_SEL_BOTH       2'h3

// Reset values
`define MIRG_RST_FLAGS      8'h00
`define MIRG_RST_ENABLE     8'h00
`define MIRG_RST_SEL        2'h0
`define MIRG_RST_PIN        1'b1
`define MIRG_RST_DEPTH      3'h0

// Shared interrupt vector address
`define MIRG_VECTOR_ADDR    16'h0008

`endif

// ### common/mirg_pkg.sv
package mirg_pkg;

    // Vector entry sequence, one-hot
    typedef enum logic [2:0] {
        MIRG_IDLE    = 3'b001,
        MIRG_ENTER   = 3'b010,
        MIRG_SERVICE = 3'b100
    } mirg_state_t;

    // Complete state of the gating block
    typedef struct packed {
        mirg_state_t state;
        logic [7:0]  flags;
        logic [7:0]  enable;
        logic        global_irq_enable;
        logic        ete;
        logic [1:0]  edge_sel;
        logic        pin_a_prev;
        logic        pin_b_prev;
        logic [2:0]  depth;
        logic [31:0] prdata;
        logic        pslverr;
    } mirg_regs_t;

endpackage

// ### rtl/mirg_irq_gate.sv
`timescale 1ns/100ps
`default_nettype none
`include "mirg_consts.svh"

module mirg_irq_gate
    import mirg_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Event sources
    input  wire logic        ext_a_pin,
    input  wire logic        ext_b_pin,
    input  wire logic        basic_timer_ovf,
    input  wire logic        timer_counter_a_ovf,
    input  wire logic        timer_counter_b_ovf,
    // CPU core side
    input  wire logic        cpu_reti,
    output logic             irq_req,
    output logic             vector_take,
    output logic      [15:0] vector_addr,
    output logic             stack_push,
    output logic             port0_wakeup
);

    mirg_regs_t s_q;
    mirg_regs_t s_d;

    logic       setup_ph;
    logic       wr_acc;
    logic       mapped;
    logic       wr_flags;
    logic       ev_a;
    logic       ev_b;
    logic       a_rise;
    logic       a_fall;
    logic       b_rise;
    logic       b_fall;
    logic [7:0] events;
    logic [7:0] pending;
    logic       any_pend;
    logic [31:0] rdata;

    // Bus phase decode
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign mapped   = (paddr == `MIRG_OFS_FLAGS) || (paddr == `MIRG_OFS_ENABLE)
                   || (paddr == `MIRG_OFS_CTRL) || (paddr == `MIRG_OFS_EDGE)
                   || (paddr == `MIRG_OFS_STATUS);
    assign wr_flags = wr_acc && (paddr == `MIRG_OFS_FLAGS);

    // Pin edge detection against last sampled level
    assign a_rise = ext_a_pin && !s_q.pin_a_prev;
    assign a_fall = !ext_a_pin && s_q.pin_a_prev;
    assign b_rise = ext_b_pin && !s_q.pin_b_prev;
    assign b_fall = !ext_b_pin && s_q.pin_b_prev;

    // Pin A edge choice from the select field
    always_comb begin
        ev_a = a_fall;
        if (s_q.ete) begin
            case (s_q.edge_sel)
                `MIRG_SEL_FALL: ev_a = a_fall;
                `MIRG_SEL_RISE: ev_a = a_rise;
                `MIRG_SEL_BOTH: ev_a = a_rise || a_fall;
                default:        ev_a = 1'b0;
            endcase
        end
    end

    // Pin B edge depends on the edge-trigger enable only
    assign ev_b = s_q.ete ? (b_rise || b_fall) : b_fall;

    // Wakeup: low level when edge mode off, else the pin triggers
    assign port0_wakeup = s_q.ete ? (ev_a || ev_b)
                                  : (!ext_a_pin || !ext_b_pin);

    // Collected events in flag layout
    always_comb begin
        events = 8'h00;
        events[`MIRG_BIT_EXT_A] = ev_a;
        events[`MIRG_BIT_EXT_B] = ev_b;
        events[`MIRG_BIT_BT]    = basic_timer_ovf;
        events[`MIRG_BIT_TCA]   = timer_counter_a_ovf;
        events[`MIRG_BIT_TCB]   = timer_counter_b_ovf;
    end

    // Enabled flags merged with no priority into one request
    assign pending  = s_q.flags & s_q.enable;
    assign any_pend = |pending;
    assign irq_req  = any_pend && s_q.global_irq_enable;

    // Read data mux, sampled in the setup phase
    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr)
            `MIRG_OFS_FLAGS:  rdata[7:0] = s_q.flags;
            `MIRG_OFS_ENABLE: rdata[7:0] = s_q.enable;
            `MIRG_OFS_CTRL:   rdata[`MIRG_BIT_GIE] = s_q.global_irq_enable;
            `MIRG_OFS_EDGE: begin
                rdata[`MIRG_BIT_ETE] = s_q.ete;
                rdata[`MIRG_SEL_HI:`MIRG_SEL_LO] = s_q.edge_sel;
            end
            `MIRG_OFS_STATUS: begin
                rdata[2:0] = s_q.depth;
                rdata[5:3] = s_q.state;
                rdata[8]   = ext_a_pin;
                rdata[9]   = ext_b_pin;
            end
            default:          rdata = 32'h0000_0000;
        endcase
    end

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.pin_a_prev = ext_a_pin;
        s_d.pin_b_prev = ext_b_pin;
        // Software clear by writing one; a new event wins
        if (wr_flags) begin
            s_d.flags = s_q.flags & ~pwdata[7:0];
        end
        s_d.flags = (s_d.flags | events) & `MIRG_SRC_MASK;
        if (setup_ph) begin
            s_d.prdata  = rdata;
            s_d.pslverr = !mapped;
        end
        if (wr_acc) begin
            case (paddr)
                `MIRG_OFS_ENABLE: s_d.enable = pwdata[7:0] & `MIRG_SRC_MASK;
                `MIRG_OFS_CTRL:   s_d.global_irq_enable = pwdata[`MIRG_BIT_GIE];
                `MIRG_OFS_EDGE: begin
                    s_d.ete      = pwdata[`MIRG_BIT_ETE];
                    s_d.edge_sel = pwdata[`MIRG_SEL_HI:`MIRG_SEL_LO];
                end
                default: s_d.enable = s_q.enable;
            endcase
        end
        // Vector entry sequence
        case (s_q.state)
            MIRG_IDLE: begin
                if (irq_req) begin
                    s_d.state = MIRG_ENTER;
                end
            end
            MIRG_ENTER: begin
                s_d.depth = s_q.depth + 3'h1;
                s_d.state = MIRG_SERVICE;
            end
            MIRG_SERVICE: begin
                if (cpu_reti) begin
                    s_d.depth = s_q.depth - 3'h1;
                    s_d.state = MIRG_IDLE;
                end
            end
            default: s_d.state = MIRG_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.state      <= MIRG_IDLE;
            s_q.flags      <= `MIRG_RST_FLAGS;
            s_q.enable     <= `MIRG_RST_ENABLE;
            s_q.global_irq_enable        <= 1'b0;
            s_q.ete        <= 1'b0;
            s_q.edge_sel   <= `MIRG_RST_SEL;
            s_q.pin_a_prev <= `MIRG_RST_PIN;
            s_q.pin_b_prev <= `MIRG_RST_PIN;
            s_q.depth      <= `MIRG_RST_DEPTH;
            s_q.prdata     <= 32'h0000_0000;
            s_q.pslverr    <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign prdata      = s_q.prdata;
    assign pslverr     = s_q.pslverr && psel && penable;
    assign pready      = 1'b1;
    assign vector_take = (s_q.state == MIRG_ENTER);
    assign stack_push  = (s_q.state == MIRG_ENTER);
    assign vector_addr = `MIRG_VECTOR_ADDR;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pinb_sets: assert property (ev_b |=> s_q.flags[`MIRG_BIT_EXT_B])
        else $error("pin B event did not set its flag");
    a_pinb_nodis: assert property (
        s_q.state == MIRG_IDLE && s_q.flags[`MIRG_BIT_EXT_B]
        && !s_q.enable[`MIRG_BIT_EXT_B] && !(pending != 8'h00)
        |=> !vector_take)
        else $error("disabled pin B caused vector entry");
    a_entry_seq: assert property (
        s_q.state == MIRG_IDLE && irq_req
        |=> vector_take && stack_push && vector_addr == 16'h0008
        ##1 !vector_take && s_q.state == MIRG_SERVICE)
        else $error("vector entry sequence wrong");
    a_bt_sets: assert property (basic_timer_ovf |=> s_q.flags[`MIRG_BIT_BT])
        else $error("basic timer flag not set");
    a_tca_sets: assert property (
        timer_counter_a_ovf |=> s_q.flags[`MIRG_BIT_TCA])
        else $error("timer counter A flag not set");
    a_tcb_sets: assert property (
        timer_counter_b_ovf |=> s_q.flags[`MIRG_BIT_TCB])
        else $error("timer counter B flag not set");
    a_tca_request: assert property (
        timer_counter_a_ovf && s_q.enable[`MIRG_BIT_TCA] && s_q.global_irq_enable
        && !(wr_acc && (paddr == `MIRG_OFS_CTRL || paddr == `MIRG_OFS_ENABLE))
        |=> irq_req)
        else $error("enabled timer counter A gave no request");
    a_gie_block: assert property (
        !s_q.global_irq_enable && s_q.state == MIRG_IDLE |=> !vector_take)
        else $error("vector taken with global enable off");
    a_flag_hold: assert property (
        s_q.flags[`MIRG_BIT_TCB] && !wr_flags |=> s_q.flags[`MIRG_BIT_TCB])
        else $error("flag dropped without software clear");
    a_set_wins: assert property (
        wr_flags && pwdata[`MIRG_BIT_BT] && basic_timer_ovf
        |=> s_q.flags[`MIRG_BIT_BT])
        else $error("event lost against clear");
    a_fall_only: assert property (
        !s_q.ete && b_rise && !s_q.flags[`MIRG_BIT_EXT_B]
        |=> !s_q.flags[`MIRG_BIT_EXT_B])
        else $error("rising edge set pin B flag in falling mode");
    a_depth_push: assert property (
        vector_take |=> s_q.depth == $past(s_q.depth) + 3'h1)
        else $error("stack level not added on entry");

    // Pin B trigger choice and latching; level-mode wakeup from a low pin A
    a_pinb_both: assert property (
        s_q.ete && (b_rise || b_fall) |=> s_q.flags[`MIRG_BIT_EXT_B])
        else $error("pin B level change missed in edge mode");
    a_pinb_fall: assert property (
        !s_q.ete && b_fall |=> s_q.flags[`MIRG_BIT_EXT_B])
        else $error("pin B falling edge missed");
    a_pinb_latch: assert property (
        ev_b && !s_q.enable[`MIRG_BIT_EXT_B] |=> s_q.flags[`MIRG_BIT_EXT_B])
        else $error("disabled pin B did not latch its flag");
    a_wake_level: assert property (
        !s_q.ete && !ext_a_pin |-> port0_wakeup)
        else $error("low pin gave no wakeup");

    // Pin A trigger choice
    a_pina_fall: assert property (
        s_q.ete && s_q.edge_sel == `MIRG_SEL_FALL && a_fall
        |=> s_q.flags[`MIRG_BIT_EXT_A])
        else $error("pin A falling edge missed");
    a_pina_rise: assert property (
        s_q.ete && s_q.edge_sel == `MIRG_SEL_RISE && a_rise
        |=> s_q.flags[`MIRG_BIT_EXT_A])
        else $error("pin A rising edge missed");
    a_pina_both: assert property (
        s_q.ete && s_q.edge_sel == `MIRG_SEL_BOTH && (a_rise || a_fall)
        |=> s_q.flags[`MIRG_BIT_EXT_A])
        else $error("pin A change missed in both-edge mode");
    a_pina_none: assert property (
        s_q.ete && s_q.edge_sel == 2'h0 && !s_q.flags[`MIRG_BIT_EXT_A]
        |=> !s_q.flags[`MIRG_BIT_EXT_A])
        else $error("pin A flag set with reserved select");

    // Timer gating
    a_bt_vector: assert property (
        s_q.state == MIRG_IDLE && s_q.global_irq_enable && s_q.flags[`MIRG_BIT_BT]
        && s_q.enable[`MIRG_BIT_BT] |=> vector_take)
        else $error("enabled basic timer gave no vector");
    a_bt_nodis: assert property (
        s_q.state == MIRG_IDLE && s_q.flags[`MIRG_BIT_BT]
        && !s_q.enable[`MIRG_BIT_BT] && pending == 8'h00 |=> !vector_take)
        else $error("disabled basic timer caused vector entry");
    a_tca_nodis: assert property (
        s_q.state == MIRG_IDLE && s_q.flags[`MIRG_BIT_TCA]
        && !s_q.enable[`MIRG_BIT_TCA] && pending == 8'h00 |=> !vector_take)
        else $error("disabled timer counter A caused vector entry");
    a_tcb_nodis: assert property (
        s_q.state == MIRG_IDLE && s_q.flags[`MIRG_BIT_TCB]
        && !s_q.enable[`MIRG_BIT_TCB] && pending == 8'h00 |=> !vector_take)
        else $error("disabled timer counter B caused vector entry");
    a_tcb_request: assert property (
        timer_counter_b_ovf && s_q.enable[`MIRG_BIT_TCB] && s_q.global_irq_enable
        && !(wr_acc && (paddr == `MIRG_OFS_CTRL || paddr == `MIRG_OFS_ENABLE))
        |=> irq_req)
        else $error("enabled timer counter B gave no request");

    // Request, vector and stack
    a_req_gie: assert property (!s_q.global_irq_enable |-> !irq_req)
        else $error("request raised with global enable off");
    a_single_vec: assert property (vector_take |-> vector_addr == 16'h0008)
        else $error("vector address not the shared vector");
    a_nest_block: assert property (s_q.state == MIRG_SERVICE |=> !vector_take)
        else $error("vector entry during service");
    a_depth_pop: assert property (
        s_q.state == MIRG_SERVICE && cpu_reti |=> s_q.depth == $past(s_q.depth) - 3'h1)
        else $error("stack level not removed on return");
    a_no_hw_clear: assert property (
        vector_take && !wr_flags
        |=> (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
        else $error("vector entry cleared a flag");

    c_vector_entry: cover property (irq_req ##1 vector_take ##[1:20] cpu_reti);
    c_both_edges: cover property (s_q.ete && b_rise ##[1:10] s_q.ete && b_fall);
    c_set_clear: cover property (wr_flags && basic_timer_ovf);
    c_disabled_latch: cover property (ev_b && !s_q.enable[`MIRG_BIT_EXT_B]);
    c_gie_off_pend: cover property (!s_q.global_irq_enable && any_pend);

endmodule

`default_nettype wire

// ### bench/mirg_core_model.sv
`timescale 1ns/100ps
`default_nettype none

module mirg_core_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Requests from the bench
    input  wire logic [2:0] ev_req,
    input  wire logic [3:0] svc_len,
    // Gating block side
    input  wire logic       vector_take,
    output logic      [2:0] ovf,
    output logic            cpu_reti
);
    logic [4:0] left_q;

    // Timer overflow pulses, and a service routine of variable length per entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf      <= 3'h0;
            cpu_reti <= 1'b0;
            left_q   <= 5'h0;
        end else begin
            ovf      <= ev_req;
            cpu_reti <= (left_q == 5'h1); // Return pulse ends the routine
            if (vector_take) begin
                left_q <= {1'b0, svc_len} + 5'h2;
            end else if (left_q != 5'h0) begin
                left_q <= left_q - 5'h1;
            end
        end
    end
endmodule

`default_nettype wire

// ### bench/mcu_interrupt_request_gating_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mirg_consts.svh"

module mcu_interrupt_request_gating_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, rnd_on;
    logic        ext_a_pin, ext_b_pin, irq_req, vector_take, stack_push, port0_wakeup;
    logic        cpu_reti, m_gie, m_pa, m_pb;
    logic [7:0]  paddr, m_flg, m_en, m_edge;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] vector_addr;
    logic [2:0]  ev_req, ovf, m_dep;
    logic [3:0]  svc_len;
    logic [1:0]  pev;
    int          m_st, fails, cmp_count, cycles;

    mirg_irq_gate i_mirg_irq_gate (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_a_pin(ext_a_pin), .ext_b_pin(ext_b_pin),
        .basic_timer_ovf(ovf[0]), .timer_counter_a_ovf(ovf[1]), .timer_counter_b_ovf(ovf[2]),
        .cpu_reti(cpu_reti), .irq_req(irq_req), .vector_take(vector_take),
        .vector_addr(vector_addr), .stack_push(stack_push), .port0_wakeup(port0_wakeup));
    mirg_core_model i_mirg_core_model (.pclk(pclk), .presetn(presetn), .ev_req(ev_req),
        .svc_len(svc_len), .vector_take(vector_take), .ovf(ovf), .cpu_reti(cpu_reti));

    // Pin events {B, A} from the previous and present pin levels
    function automatic logic [1:0] evt(input logic pa, input logic pb);
        if (m_edge[7]) begin
            return {pb != m_pb, (m_edge[3] & m_pa & !pa) | (m_edge[4] & !m_pa & pa)};
        end
        return {m_pb & !pb, m_pa & !pa};
    endfunction

    function automatic logic m_irq();
        return (|(m_flg & m_en)) & m_gie;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reference model, stepped on the same edges as the block
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {m_flg, m_en, m_edge, m_gie, m_pa, m_pb, m_dep} = {25'h0, 2'b11, 3'h0};
            m_st = 0;
        end else begin
            pev = evt(ext_a_pin, ext_b_pin);
            if (m_st == 0 && m_irq()) begin
                m_st = 1;
                m_dep = m_dep + 3'h1;
            end else if (m_st == 1) begin
                m_st = 2;
            end else if (m_st == 2 && cpu_reti) begin
                m_st = 0;
                m_dep = m_dep - 3'h1;
            end
            if (psel && penable && pwrite) begin
                case (paddr)
                    `MIRG_OFS_FLAGS:  m_flg = m_flg & ~pwdata[7:0];
                    `MIRG_OFS_ENABLE: m_en = pwdata[7:0] & 8'h73;
                    `MIRG_OFS_CTRL:   m_gie = pwdata[7];
                    `MIRG_OFS_EDGE:   m_edge = pwdata[7:0] & 8'h98;
                    default:          m_gie = m_gie;
                endcase
            end
            m_flg = m_flg | {1'b0, ovf, 2'b00, pev};
            m_pa = ext_a_pin;
            m_pb = ext_b_pin;
        end
    end

    // Per-cycle comparison of the core-side outputs
    always @(negedge pclk) begin
        if (presetn) begin
            chk(irq_req, m_irq());
            chk(vector_take, m_st == 1);
            chk(stack_push, m_st == 1);
            chk(vector_addr, 16'h0008);
            chk(port0_wakeup, m_edge[7] ? |evt(ext_a_pin, ext_b_pin) : !(ext_a_pin & ext_b_pin));
        end
    end

    // Random overflows and pin levels, and a hang limit
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        ev_req <= rnd_on ? 3'($random(seed)) : 3'h0;
        if (rnd_on) begin
            {ext_a_pin, ext_b_pin} <= 2'($random(seed));
        end
        if (cycles == 8000) begin
            fails++;
            close_out;
        end
    end

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, rnd_on, paddr, pwdata, svc_len} = 49'h0;
        {ext_a_pin, ext_b_pin, seed, cycles} = {2'b11, 32'h88b5e53b, 32'h0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MIRG_OFS_FLAGS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        for (int r = 0; r < 16; r++) begin
            apb(1'b1, `MIRG_OFS_EDGE, {24'h0, r[0], 2'b00, r[2:1], 3'h0});
            apb(1'b1, `MIRG_OFS_CTRL, {24'h0, r[3], 7'h0});
            apb(1'b1, `MIRG_OFS_ENABLE, 32'($random(seed)) & 32'h73);
            svc_len <= 4'($random(seed));
            rnd_on <= 1'b1;
            repeat (30) @(posedge pclk);
            apb(1'b1, `MIRG_OFS_FLAGS, 32'($random(seed)) & 32'h73);
            repeat (30) @(posedge pclk);
            rnd_on <= 1'b0;
            apb(1'b1, `MIRG_OFS_ENABLE, 32'h0);
            repeat (24) @(posedge pclk);
            apb(1'b0, `MIRG_OFS_FLAGS, 32'h0);
            chk(rd, {24'h0, m_flg});
            apb(1'b0, `MIRG_OFS_STATUS, 32'h0);
            chk(rd, {22'h0, ext_b_pin, ext_a_pin, 2'b00, 3'(1 << m_st), m_dep});
            $display("round %0d done, mismatches %0d", r, fails);
        end
        close_out;
    end
endmodule

`default_nettype wire
